/* File: core/spp_pkg.sv */
package spp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] START_VEL_OFS = 8'h04;
  localparam logic [7:0] MAX_VEL_OFS = 8'h08;
  localparam logic [7:0] ACCEL_OFS = 8'h0C;
  localparam logic [7:0] LENGTH_OFS = 8'h10;
  localparam logic [7:0] FEEDBACK_OFS = 8'h14;
  localparam logic [7:0] POSITION_OFS = 8'h18;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_REF_BIT = 2;
  localparam int CTRL_REFFIT_BIT = 3;
  // feedback fields
  localparam int FB_BUSY_BIT = 24;
  localparam int FB_CONF_BIT = 25;
  localparam int FB_ABORT_BIT = 26;
  localparam int FB_DIR_BIT = 27;
  localparam int FB_PULSE_BIT = 28;
  // interrupt bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_REF_BIT = 2;
  localparam int IRQ_W = 3;
  // widths and reset values
  localparam int VEL_W = 16;
  localparam int LEN_W = 24;
  localparam int ACC_W = 24;
  localparam logic [VEL_W-1:0] START_VEL_RST = 16'h0100;
  localparam logic [VEL_W-1:0] MAX_VEL_RST = 16'h1000;
  localparam logic [VEL_W-1:0] ACCEL_RST = 16'h0010;
  localparam logic [LEN_W-1:0] LENGTH_RST = 24'h000000;
  localparam logic [LEN_W-1:0] REF_SEARCH_LEN = 24'hFFFFFF;
  // direction settle time before first step
  localparam int CLK_MHZ = 100;
  localparam int DIR_SETTLE_NS = 1000;
  localparam int DIR_SETTLE_CYC = (DIR_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SETTLE_LAST = 8'(DIR_SETTLE_CYC - 1);

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_FWD = 2'b01,
    MODE_BWD = 2'b10,
    MODE_NEUTRAL = 2'b11
  } spp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_ACCEL = 3'b010,
    ST_CRUISE = 3'b011,
    ST_DECEL = 3'b100
  } spp_state_t;
endpackage

/* File: core/spp_stepper_positioner.sv */
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// How it works
// - each step pulse lowers the distance to go by one and the job ends when it reaches zero.
// - a phase accumulator adds the present velocity every cycle, so pulse rate follows velocity.
// - velocity climbs by the acceleration per pulse, cruises, then falls by the same amount per pulse.
// - a limit switch in the travel direction halts the traverse and flags an abort.
// - the external stop input sends the motion into the deceleration ramp down to start speed.
// - the pulse inhibit input kills pulse output in the same cycle it is seen, with no ramp.
// - reference approach searches for the reference switch, or zeroes position at once if none is fitted.
// - a feedback word with distance to go and status bits is refreshed every cycle for the host.
// - configured, pulsing and aborted indicators are driven as outputs.
// - the mode field takes stop, start forwards, start backwards and neutral.
// - the motion engine runs on its own and never waits on the bus.
module spp_stepper_positioner (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic limitFwd,
  input wire logic limitBwd,
  input wire logic extStop,
  input wire logic pulse_inhibit_input,
  input wire logic refSwitch,
  output logic stepOut,
  output logic dirOut,
  output logic configuredIndicator,
  output logic pulsing_indicator,
  output logic aborted_indicator,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [4:0] syncA;
  logic [4:0] syncB;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
    end else begin
      syncA <= {refSwitch, pulse_inhibit_input, extStop, limitBwd, limitFwd};
      syncB <= syncA;
    end
  end
  wire limFwdS = syncB[0];
  wire limBwdS = syncB[1];
  wire extStopS = syncB[2];
  wire inhibitS = syncB[3];
  wire refS = syncB[4];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [1:0] mode;
  logic refApproach;
  logic refFitted;
  logic [spp_pkg::VEL_W-1:0] startVel;
  logic [spp_pkg::VEL_W-1:0] maxVel;
  logic [spp_pkg::VEL_W-1:0] accelStep;
  logic [spp_pkg::LEN_W-1:0] pathLen;
  logic [spp_pkg::IRQ_W-1:0] irqStat;
  logic [spp_pkg::IRQ_W-1:0] irqMask;
  logic [spp_pkg::LEN_W-1:0] remaining;
  logic [spp_pkg::LEN_W-1:0] position;
  logic [31:0] feedback;
  spp_pkg::spp_state_t state;

  wire accessDone = psel & penable & pready;
  wire wrEn = accessDone & pwrite;
  wire selCtrl = paddr == spp_pkg::CTRL_OFS;
  wire selStart = paddr == spp_pkg::START_VEL_OFS;
  wire selMax = paddr == spp_pkg::MAX_VEL_OFS;
  wire selAcc = paddr == spp_pkg::ACCEL_OFS;
  wire selLen = paddr == spp_pkg::LENGTH_OFS;
  wire selFb = paddr == spp_pkg::FEEDBACK_OFS;
  wire selPos = paddr == spp_pkg::POSITION_OFS;
  wire selStat = paddr == spp_pkg::IRQ_STAT_OFS;
  wire selMask = paddr == spp_pkg::IRQ_MASK_OFS;
  wire mapped = selCtrl | selStart | selMax | selAcc | selLen | selFb | selPos | selStat | selMask;
  wire ctrlWr = wrEn & selCtrl;
  wire cfgWr = wrEn & (selStart | selMax | selAcc);
  wire [1:0] wrMode = pwdata[spp_pkg::CTRL_MODE_LSB +: 2];
  wire wrRef = pwdata[spp_pkg::CTRL_REF_BIT];
  wire wrRefFit = pwdata[spp_pkg::CTRL_REFFIT_BIT];

  wire [31:0] readMux =
    selCtrl ? {28'h0000000, refFitted, refApproach, mode} :
    selStart ? {16'h0000, startVel} :
    selMax ? {16'h0000, maxVel} :
    selAcc ? {16'h0000, accelStep} :
    selLen ? {8'h00, pathLen} :
    selFb ? feedback :
    selPos ? {8'h00, position} :
    selStat ? {29'h00000000, irqStat} :
    selMask ? {29'h00000000, irqMask} : 32'h00000000;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= (psel & penable & ~pready & ~pwrite) ? readMux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= spp_pkg::MODE_NEUTRAL;
      refApproach <= 1'b0;
      refFitted <= 1'b0;
      startVel <= spp_pkg::START_VEL_RST;
      maxVel <= spp_pkg::MAX_VEL_RST;
      accelStep <= spp_pkg::ACCEL_RST;
      pathLen <= spp_pkg::LENGTH_RST;
      irqMask <= 3'h0;
    end else begin
      if (ctrlWr) begin
        mode <= wrMode;
        refApproach <= wrRef;
        refFitted <= wrRefFit;
      end
      if (wrEn & selStart)
        startVel <= pwdata[spp_pkg::VEL_W-1:0];
      if (wrEn & selMax)
        maxVel <= pwdata[spp_pkg::VEL_W-1:0];
      if (wrEn & selAcc)
        accelStep <= pwdata[spp_pkg::VEL_W-1:0];
      if (wrEn & selLen)
        pathLen <= pwdata[spp_pkg::LEN_W-1:0];
      if (wrEn & selMask)
        irqMask <= pwdata[spp_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // motion engine
  logic [spp_pkg::ACC_W-1:0] phaseAcc;
  logic [spp_pkg::VEL_W-1:0] vel;
  logic [spp_pkg::LEN_W-1:0] rampCnt;
  logic [7:0] settleCnt;
  logic stopReq;
  logic refRun;
  logic aborted;

  wire busy = state != spp_pkg::ST_IDLE;
  wire moving = busy & (state != spp_pkg::ST_SETTLE);
  wire startFwd = ctrlWr & (wrMode == spp_pkg::MODE_FWD);
  wire startBwd = ctrlWr & (wrMode == spp_pkg::MODE_BWD);
  wire stopCmd = ctrlWr & (wrMode == spp_pkg::MODE_STOP);
  wire refNoSwitch = (startFwd | startBwd) & wrRef & ~wrRefFit & ~busy;
  wire startJob = (startFwd | startBwd) & ~busy & ~refNoSwitch & ~inhibitS;
  wire [spp_pkg::ACC_W:0] accSum = {1'b0, phaseAcc} + {8'h00, vel};
  wire stepNow = moving & accSum[spp_pkg::ACC_W];
  wire limitHit = moving & (dirOut ? limBwdS : limFwdS);
  wire refHit = moving & refRun & refS;
  wire killNow = busy & inhibitS;
  wire [spp_pkg::LEN_W-1:0] remNext = remaining - 24'h000001;
  wire lastStep = stepNow & (remNext == 24'h000000);
  wire [spp_pkg::VEL_W:0] velUp = {1'b0, vel} + {1'b0, accelStep};
  wire [spp_pkg::VEL_W:0] velDn = {1'b0, vel} - {1'b0, accelStep};
  wire upSat = velUp >= {1'b0, maxVel};
  wire dnSat = velDn[spp_pkg::VEL_W] | (velDn[spp_pkg::VEL_W-1:0] <= startVel);
  wire needDecel = remNext <= rampCnt + 24'h000001;
  wire rampDone = stopReq & dnSat & stepNow;
  wire hardStop = killNow | limitHit | refHit;
  wire jobEnd = hardStop | lastStep | rampDone;
  wire stopAsk = busy & (extStopS | stopCmd);

  spp_pkg::spp_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      spp_pkg::ST_IDLE: begin
        if (startJob)
          next_state = spp_pkg::ST_SETTLE;
      end
      spp_pkg::ST_SETTLE: begin
        if (killNow | stopAsk)
          next_state = spp_pkg::ST_IDLE;
        else if (settleCnt == spp_pkg::SETTLE_LAST)
          next_state = spp_pkg::ST_ACCEL;
      end
      spp_pkg::ST_ACCEL: begin
        if (jobEnd)
          next_state = spp_pkg::ST_IDLE;
        else if (stopAsk | (stepNow & needDecel))
          next_state = spp_pkg::ST_DECEL;
        else if (stepNow & upSat)
          next_state = spp_pkg::ST_CRUISE;
      end
      spp_pkg::ST_CRUISE: begin
        if (jobEnd)
          next_state = spp_pkg::ST_IDLE;
        else if (stopAsk | (stepNow & needDecel))
          next_state = spp_pkg::ST_DECEL;
      end
      spp_pkg::ST_DECEL: begin
        if (jobEnd)
          next_state = spp_pkg::ST_IDLE;
      end
      default: next_state = spp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= spp_pkg::ST_IDLE;
      settleCnt <= 8'h00;
    end else begin
      state <= next_state;
      settleCnt <= (state == spp_pkg::ST_SETTLE) ? settleCnt + 8'h01 : 8'h00;
    end
  end

  // velocity and ramp bookkeeping
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vel <= 16'h0000;
      phaseAcc <= 24'h000000;
      rampCnt <= 24'h000000;
      stopReq <= 1'b0;
    end else if (!moving || jobEnd) begin
      vel <= startVel;
      phaseAcc <= 24'h000000;
      rampCnt <= 24'h000000;
      stopReq <= 1'b0;
    end else begin
      phaseAcc <= accSum[spp_pkg::ACC_W-1:0];
      if (stopAsk)
        stopReq <= 1'b1;
      if (stepNow && state == spp_pkg::ST_ACCEL) begin
        vel <= upSat ? maxVel : velUp[spp_pkg::VEL_W-1:0];
        rampCnt <= rampCnt + 24'h000001;
      end else if (stepNow && state == spp_pkg::ST_DECEL) begin
        vel <= dnSat ? startVel : velDn[spp_pkg::VEL_W-1:0];
      end
    end
  end

  // distance, position, direction and step pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remaining <= 24'h000000;
      position <= 24'h000000;
      dirOut <= 1'b0;
      stepOut <= 1'b0;
      refRun <= 1'b0;
    end else begin
      stepOut <= stepNow & ~killNow;
      if (startJob) begin
        dirOut <= startBwd;
        refRun <= wrRef;
        remaining <= wrRef ? spp_pkg::REF_SEARCH_LEN : pathLen;
      end else if (refNoSwitch | refHit) begin
        position <= 24'h000000;
        remaining <= 24'h000000;
      end else if (stepNow & ~killNow) begin
        remaining <= remNext;
        position <= dirOut ? position - 24'h000001 : position + 24'h000001;
      end else if (!busy) begin
        refRun <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, indicators, interrupts
  wire [spp_pkg::IRQ_W-1:0] irqEvent;
  assign irqEvent[spp_pkg::IRQ_DONE_BIT] = busy & (lastStep | rampDone) & ~hardStop;
  assign irqEvent[spp_pkg::IRQ_ABORT_BIT] = (killNow | limitHit) | (startJob & 1'b0);
  assign irqEvent[spp_pkg::IRQ_REF_BIT] = refHit | refNoSwitch;
  wire [spp_pkg::IRQ_W-1:0] irqClr = (wrEn & selStat) ? pwdata[spp_pkg::IRQ_W-1:0] : 3'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat <= 3'h0;
      irq <= 1'b0;
      aborted <= 1'b0;
      configuredIndicator <= 1'b0;
      pulsing_indicator <= 1'b0;
      aborted_indicator <= 1'b0;
      feedback <= 32'h00000000;
    end else begin
      // a new event wins over a same-cycle clear
      irqStat <= (irqStat & ~irqClr) | irqEvent;
      irq <= |(((irqStat & ~irqClr) | irqEvent) & irqMask);
      if (killNow | limitHit)
        aborted <= 1'b1;
      else if (startJob)
        aborted <= 1'b0;
      if (cfgWr)
        configuredIndicator <= 1'b1;
      pulsing_indicator <= moving & ~jobEnd;
      aborted_indicator <= aborted;
      feedback <= {3'b000, moving, dirOut, aborted, configuredIndicator, busy, remaining};
    end
  end

endmodule

/* File: verif/spp_stepper_positioner_asserts.sv */
`timescale 1ns/1ps
module spp_stepper_positioner_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic limitFwd,
  input wire logic pulse_inhibit_input,
  input wire logic stepOut,
  input wire logic dirOut,
  input wire logic configuredIndicator,
  input wire logic pulsing_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_stepPulse; stepOut |=> !stepOut; endproperty
  a_stepPulse: assert property (p_stepPulse) else $error("step pulse too long");
  property p_dirHold; pulsing_indicator && $past(pulsing_indicator) |-> $stable(dirOut); endproperty
  a_dirHold: assert property (p_dirHold) else $error("direction moved in job");
  // sync latency plus one engine cycle
  property p_inhibit; pulse_inhibit_input [*5] |-> !stepOut && !pulsing_indicator; endproperty
  a_inhibit: assert property (p_inhibit) else $error("steps under inhibit");
  property p_limit; (limitFwd && !dirOut) [*5] |-> !stepOut; endproperty
  a_limit: assert property (p_limit) else $error("steps past limit");
  property p_stepActive; stepOut |-> pulsing_indicator || $past(pulsing_indicator); endproperty
  a_stepActive: assert property (p_stepActive) else $error("step without pulsing");
  property p_ready; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
  a_ready: assert property (p_ready) else $error("ready timing");
  property p_readyPulse; pready |=> !pready; endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("ready held");
  property p_errReady; pslverr |-> pready; endproperty
  a_errReady: assert property (p_errReady) else $error("error without ready");
  property p_dataIdle; !pready |-> prdata == 32'h00000000; endproperty
  a_dataIdle: assert property (p_dataIdle) else $error("read data outside answer");
  property p_cfgSticky; configuredIndicator |=> configuredIndicator; endproperty
  a_cfgSticky: assert property (p_cfgSticky) else $error("configured dropped");
endmodule

/* File: verif/spp_motor_model.sv */
`timescale 1ns/1ps
// power section stand-in: counts steps and tracks shaft position
module spp_motor_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stepOut,
  input wire logic dirOut,
  output int steps,
  output int position
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      steps <= 0;
      position <= 0;
    end else if (stepOut) begin
      steps <= steps + 1;
      position <= dirOut ? position - 1 : position + 1;
    end
  end
endmodule

/* File: verif/test_spp_stepper_positioner.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_spp_stepper_positioner;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic stepOut, dirOut, cfgInd, pulsing, aborted, irq;
  logic limitFwd = 0, limitBwd = 0, extStop = 0, inhibit = 0, refSwitch = 0;
  int miscompares = 0, compares = 0, steps, position, base, hit;
  logic [31:0] rv[4] = '{{16'h0, spp_pkg::START_VEL_RST}, {16'h0, spp_pkg::MAX_VEL_RST},
    {16'h0, spp_pkg::ACCEL_RST}, {8'h0, spp_pkg::LENGTH_RST}};
  always #5 clk = ~clk;
  spp_stepper_positioner dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .limitFwd(limitFwd),
    .limitBwd(limitBwd), .extStop(extStop), .pulse_inhibit_input(inhibit), .refSwitch(refSwitch),
    .stepOut(stepOut), .dirOut(dirOut), .configuredIndicator(cfgInd), .pulsing_indicator(pulsing),
    .aborted_indicator(aborted), .irq(irq));
  spp_motor_model motor (.clk(clk), .arst_n(arst_n), .stepOut(stepOut), .dirOut(dirOut), .steps(steps),
    .position(position));
  ////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic waitIrq();
    for (int i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge clk);
    if (irq !== 1'b1) miscompares++;
    // last step is registered with irq; let the motor count it
    repeat (2) @(posedge clk);
  endtask
  task automatic waitSteps(input int n);
    for (int i = 0; i < 40000 && steps < base + n; i++) @(posedge clk);
    if (steps < base + n) miscompares++;
  endtask
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(4 + 4 * i), 0);
      `CHK("resetVal", rv[i], q)
    end
    apb(0, 8'h40, 0);
    `CHK("unmapped", 1'b1, err)
    apb(1, spp_pkg::START_VEL_OFS, 32'h0000C000);
    apb(1, spp_pkg::MAX_VEL_OFS, 32'h0000FFFF);
    apb(1, spp_pkg::ACCEL_OFS, 32'h00000800);
    apb(1, spp_pkg::IRQ_MASK_OFS, 32'h00000007);
    apb(0, spp_pkg::FEEDBACK_OFS, 0);
    `CHK("cfgBit", 1'b1, q[spp_pkg::FB_CONF_BIT])
    `CHK("cfgLed", 1'b1, cfgInd)
    $display("test config done");
    for (int i = 0; i < 2; i++) begin
      base = steps;
      hit = position;
      apb(1, spp_pkg::LENGTH_OFS, 32'(10 - 5 * i));
      apb(1, spp_pkg::CTRL_OFS, 32'(1 + i));
      waitIrq();
      `CHK("steps", 10 - 5 * i, steps - base)
      `CHK("travel", i ? -5 : 10, position - hit)
      apb(0, spp_pkg::FEEDBACK_OFS, 0);
      `CHK("distToGo", 24'h000000, q[23:0])
      apb(0, spp_pkg::IRQ_STAT_OFS, 0);
      `CHK("doneStat", 32'h00000001, q)
      apb(1, spp_pkg::IRQ_STAT_OFS, 32'h00000007);
      repeat (2) @(posedge clk);
      `CHK("irqClear", 1'b0, irq)
    end
    $display("test jobs done");
    // 0 inhibit, 1 limit, 2 external stop, 3 stop mode
    for (int j = 0; j < 4; j++) begin
      base = steps;
      apb(1, spp_pkg::LENGTH_OFS, 32'd400);
      apb(1, spp_pkg::CTRL_OFS, 32'd1);
      waitSteps(10);
      `CHK("pulsingLed", 1'b1, pulsing)
      hit = steps;
      if (j == 3) apb(1, spp_pkg::CTRL_OFS, 32'd0);
      else begin
        @(posedge clk);
        inhibit <= (j == 0);
        limitFwd <= (j == 1);
        extStop <= (j == 2);
      end
      waitIrq();
      hit = steps - hit;
      `CHK("abrupt", j < 2, hit < 2)
      base = steps;
      repeat (600) @(posedge clk);
      `CHK("halted", base, steps)
      `CHK("abortLed", j < 2, aborted)
      apb(0, spp_pkg::IRQ_STAT_OFS, 0);
      `CHK("endStat", j < 2 ? 32'h00000002 : 32'h00000001, q)
      inhibit <= 0;
      limitFwd <= 0;
      extStop <= 0;
      apb(1, spp_pkg::IRQ_STAT_OFS, 32'h00000007);
    end
    $display("test stops done");
    base = steps;
    apb(1, spp_pkg::CTRL_OFS, 32'd3);
    repeat (300) @(posedge clk);
    `CHK("neutral", base, steps)
    apb(1, spp_pkg::IRQ_MASK_OFS, 0);
    // reference approach without a fitted switch needs a start mode
    apb(1, spp_pkg::CTRL_OFS, 32'h00000005);
    repeat (10) @(posedge clk);
    `CHK("masked", 1'b0, irq)
    apb(0, spp_pkg::POSITION_OFS, 0);
    `CHK("refZero", 32'h00000000, q)
    apb(1, spp_pkg::IRQ_MASK_OFS, 32'h00000007);
    repeat (3) @(posedge clk);
    `CHK("unmasked", 1'b1, irq)
    apb(1, spp_pkg::IRQ_STAT_OFS, 32'h00000007);
    base = steps;
    apb(1, spp_pkg::CTRL_OFS, 32'h0000000D);
    waitSteps(3);
    refSwitch <= 1;
    waitIrq();
    apb(0, spp_pkg::IRQ_STAT_OFS, 0);
    `CHK("refStat", 32'h00000004, q)
    apb(0, spp_pkg::POSITION_OFS, 0);
    `CHK("refPos", 32'h00000000, q)
    refSwitch <= 0;
    $display("test reference done");
    test_done();
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
bind spp_stepper_positioner spp_stepper_positioner_asserts chk (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .limitFwd(limitFwd),
  .pulse_inhibit_input(pulse_inhibit_input), .stepOut(stepOut), .dirOut(dirOut),
  .configuredIndicator(configuredIndicator), .pulsing_indicator(pulsing_indicator));
